// *** hw/hdc_pkg.sv ***
/*
  hdc_pkg: register map, field positions, reset values and encodings for the
  holdover and tuning DAC control block.
  Assumes a 32-bit AXI4-Lite register bus with 12-bit byte addresses.
*/
package hdc_pkg;
  // byte addresses: four times the register index
  localparam logic [11:0] ADDR_SWITCH_CFG  = 12'h034;
  localparam logic [11:0] ADDR_TRIP_CFG    = 12'h038;
  localparam logic [11:0] ADDR_DAC_CTRL    = 12'h03C;
  localparam logic [11:0] ADDR_XTAL_CFG    = 12'h040;
  localparam logic [11:0] ADDR_READBACK    = 12'h05C;
  localparam logic [11:0] ADDR_LF_DLY_CFG  = 12'h060;
  localparam logic [11:0] ADDR_STATUS      = 12'h080;

  // writable bits; everything else reads as zero
  localparam logic [31:0] MASK_SWITCH_CFG  = 32'h0000_8000;
  localparam logic [31:0] MASK_TRIP_CFG    = 32'h000F_CFE0;
  localparam logic [31:0] MASK_DAC_CTRL    = 32'hFFDF_FFE0;
  localparam logic [31:0] MASK_XTAL_CFG    = 32'hC000_0000;
  localparam logic [31:0] MASK_LF_DLY_CFG  = 32'hFF77_7700;

  localparam logic [31:0] RST_REG          = 32'h0000_0000;

  // field positions
  localparam int LOCK_MASK_BIT   = 15;
  localparam int CEIL_TRIP_LSB   = 14;
  localparam int FLOOR_TRIP_LSB  = 6;
  localparam int RAIL_EN_BIT     = 5;
  localparam int FIXED_VAL_LSB   = 22;
  localparam int FIXED_SEL_BIT   = 20;
  localparam int EXIT_CNT_LSB    = 6;
  localparam int FORCE_BIT       = 5;
  localparam int CRYSTAL_DRIVE_LEVEL_LSB    = 30;
  localparam int READBACK_LSB    = 14;
  localparam int C4_LSB          = 28;
  localparam int C3_LSB          = 24;
  localparam int R4_LSB          = 20;
  localparam int R3_LSB          = 16;
  localparam int FB_DLY_LSB      = 12;
  localparam int REF_DLY_LSB     = 8;

  // widths
  localparam int DAC_W  = 10;
  localparam int TRIP_W = 6;
  localparam int CNT_W  = 14;

  // full-scale figures for the trip comparison
  localparam logic [15:0] DAC_FULL_SCALE = 16'h03FF;
  localparam logic [6:0]  TRIP_STEPS     = 7'h40;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    HDC_TRACK = 2'b00,
    HDC_HOLD  = 2'b01
  } hdc_state_t;
endpackage

// *** hw/hdc_trip_cmp.sv ***
/*
  hdc_trip_cmp: compares a DAC code against a six-bit trip threshold.
  Floor form trips at or below (n+1)/64 of full scale, ceiling form at or
  above full scale less (n+1)/64. Pure combinational; caller registers.
*/
`timescale 1ns/100ps
module hdc_trip_cmp #(
  parameter bit IS_CEIL = 1'b0
) (
  // compare operands
  input  wire logic [9:0] code,
  input  wire logic [5:0] thr,
  // result
  output logic            hit
);
  logic [15:0] code_scaled;
  logic [6:0]  steps;
  logic [31:0] level_full;
  logic [15:0] level;

  // scale both sides by 64*1023 so the comparison is exact
  assign code_scaled = {code, 6'h00};
  assign steps       = IS_CEIL ? (hdc_pkg::TRIP_STEPS - 7'h01 - {1'b0, thr})
                               : ({1'b0, thr} + 7'h01);
  assign level_full  = {25'h0000000, steps} * {16'h0000, hdc_pkg::DAC_FULL_SCALE};
  assign level       = level_full[15:0];
  assign hit         = IS_CEIL ? (code_scaled >= level) : (code_scaled <= level);
endmodule // hdc_trip_cmp

// *** hw/hdc_exit_counter.sv ***
/*
  hdc_exit_counter: counts phase-detector ticks during which the loop lock
  indication stays high; done once the programmed count is reached.
  Assumes tick and lock are synchronous to clk.
*/
`timescale 1ns/100ps
module hdc_exit_counter (
  // clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // control
  input  wire logic        clear,
  input  wire logic        tick,
  input  wire logic        lock,
  input  wire logic [13:0] target,
  // result
  output logic             done_q
);
  logic [13:0] cnt_q;
  logic [13:0] cnt_d;
  logic [13:0] goal;

  // code 0 is reserved; treated as 1 so the block cannot leave at once
  assign goal  = (target == 14'h0000) ? 14'h0001 : target;
  assign cnt_d = (clear || !lock) ? 14'h0000 :
                 (tick && cnt_q < goal) ? cnt_q + 14'h0001 : cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q  <= 14'h0000;
      done_q <= 1'b0;
    end else if (ce) begin
      cnt_q  <= cnt_d;
      done_q <= (cnt_d >= goal);
    end
  end
endmodule // hdc_exit_counter

// *** hw/hdc_holdover_ctrl.sv ***
/*
  hdc_holdover_ctrl: AXI4-Lite register file and holdover control for the
  first loop's tuning DAC: trip detection, fixed/tracked DAC, forced
  holdover, lock-count exit, plus static loop-filter and delay settings.
  Assumes dac_track_in, pd_tick and loop1_lock_indicator are synchronous
  to aclk; pd_tick is high one cycle per phase-detector period.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module hdc_holdover_ctrl (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // first loop inputs
  input  wire logic [9:0]  dac_track_in,
  input  wire logic        pd_tick,
  input  wire logic        loop1_lock_indicator,
  // tuning dac and status
  output logic [9:0]       dac_code_q,
  output logic             holdover_q,
  output logic             switch_event_q,
  output logic             dac_floor_flag_q,
  output logic             dac_ceiling_flag_q,
  // static analog settings
  output logic [1:0]       crystal_drive_level,
  output logic [3:0]       loop2_cap_c4_select,
  output logic [3:0]       loop2_cap_c3_select,
  output logic [2:0]       loop2_res_r4_select,
  output logic [2:0]       loop2_res_r3_select,
  output logic [2:0]       loop1_feedback_delay,
  output logic [2:0]       loop1_reference_delay
);
  // register bank
  logic [31:0] switch_cfg_q, trip_cfg_q, dac_ctrl_q, xtal_cfg_q, lf_dly_cfg_q;
  logic [9:0]  trk_q;
  logic        lock_prev_q;
  hdc_pkg::hdc_state_t state_q, state_d;

  // bus state
  logic        aw_have_q, w_have_q;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // write channel handshakes
  wire aw_take    = s_axi_awvalid & s_axi_awready;
  wire w_take     = s_axi_wvalid & s_axi_wready;
  wire do_write   = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire aw_have_d  = do_write ? 1'b0 : (aw_have_q | aw_take);
  wire w_have_d   = do_write ? 1'b0 : (w_have_q | w_take);
  wire bvalid_d   = do_write | (s_axi_bvalid & ~s_axi_bready);

  // write decode
  wire wr_switch  = do_write && aw_addr_q == hdc_pkg::ADDR_SWITCH_CFG;
  wire wr_trip    = do_write && aw_addr_q == hdc_pkg::ADDR_TRIP_CFG;
  wire wr_ctrl    = do_write && aw_addr_q == hdc_pkg::ADDR_DAC_CTRL;
  wire wr_xtal    = do_write && aw_addr_q == hdc_pkg::ADDR_XTAL_CFG;
  wire wr_lf      = do_write && aw_addr_q == hdc_pkg::ADDR_LF_DLY_CFG;
  wire wr_ok      = wr_switch | wr_trip | wr_ctrl | wr_xtal | wr_lf;

  // read channel
  wire ar_take    = s_axi_arvalid & s_axi_arready;
  wire rvalid_d   = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] status_word = {27'h0000000, loop1_lock_indicator, dac_ceiling_flag_q,
                             dac_floor_flag_q, switch_event_q, holdover_q};
  // read-back holds only the tracked code; writes to it are refused
  wire [31:0] readback_word = {8'h00, trk_q, 14'h0000};
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == hdc_pkg::ADDR_SWITCH_CFG) begin
      rd_word = switch_cfg_q;
    end else if (s_axi_araddr == hdc_pkg::ADDR_TRIP_CFG) begin
      rd_word = trip_cfg_q;
    end else if (s_axi_araddr == hdc_pkg::ADDR_DAC_CTRL) begin
      rd_word = dac_ctrl_q;
    end else if (s_axi_araddr == hdc_pkg::ADDR_XTAL_CFG) begin
      rd_word = xtal_cfg_q;
    end else if (s_axi_araddr == hdc_pkg::ADDR_READBACK) begin
      rd_word = readback_word;
    end else if (s_axi_araddr == hdc_pkg::ADDR_LF_DLY_CFG) begin
      rd_word = lf_dly_cfg_q;
    end else if (s_axi_araddr == hdc_pkg::ADDR_STATUS) begin
      rd_word = status_word;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // field views
  wire        lock_mask   = switch_cfg_q[hdc_pkg::LOCK_MASK_BIT];
  wire [5:0]  floor_thr   = trip_cfg_q[hdc_pkg::FLOOR_TRIP_LSB +: hdc_pkg::TRIP_W];
  wire [5:0]  ceil_thr    = trip_cfg_q[hdc_pkg::CEIL_TRIP_LSB +: hdc_pkg::TRIP_W];
  wire        rail_en     = trip_cfg_q[hdc_pkg::RAIL_EN_BIT];
  wire [9:0]  fixed_val   = dac_ctrl_q[hdc_pkg::FIXED_VAL_LSB +: hdc_pkg::DAC_W];
  wire        fixed_sel   = dac_ctrl_q[hdc_pkg::FIXED_SEL_BIT];
  wire [13:0] exit_cnt    = dac_ctrl_q[hdc_pkg::EXIT_CNT_LSB +: hdc_pkg::CNT_W];
  wire        force_hold  = dac_ctrl_q[hdc_pkg::FORCE_BIT];

  // static settings come straight from register flops; reserved codes are
  // passed through unchanged, software must keep out of them
  assign crystal_drive_level   = xtal_cfg_q[hdc_pkg::CRYSTAL_DRIVE_LEVEL_LSB +: 2];
  assign loop2_cap_c4_select   = lf_dly_cfg_q[hdc_pkg::C4_LSB +: 4];
  assign loop2_cap_c3_select   = lf_dly_cfg_q[hdc_pkg::C3_LSB +: 4];
  assign loop2_res_r4_select   = lf_dly_cfg_q[hdc_pkg::R4_LSB +: 3];
  assign loop2_res_r3_select   = lf_dly_cfg_q[hdc_pkg::R3_LSB +: 3];
  assign loop1_feedback_delay  = lf_dly_cfg_q[hdc_pkg::FB_DLY_LSB +: 3];
  assign loop1_reference_delay = lf_dly_cfg_q[hdc_pkg::REF_DLY_LSB +: 3];

  // trip detection on the code actually driven onto the DAC
  logic floor_hit, ceil_hit;
  hdc_trip_cmp #(.IS_CEIL(1'b0)) u_floor (
    .code (dac_code_q),
    .thr  (floor_thr),
    .hit  (floor_hit)
  );
  hdc_trip_cmp #(.IS_CEIL(1'b1)) u_ceil (
    .code (dac_code_q),
    .thr  (ceil_thr),
    .hit  (ceil_hit)
  );

  wire rail_trip  = rail_en & (floor_hit | ceil_hit);
  wire trip_rise  = rail_trip & ~(rail_en & (dac_floor_flag_q | dac_ceiling_flag_q));
  wire lock_fall  = lock_prev_q & ~loop1_lock_indicator;
  wire lock_event = lock_fall & ~lock_mask;
  // forcing is deliberately absent from the switch term
  wire switch_d   = (rail_en & trip_rise) | lock_event;

  // holdover state
  logic exit_done;
  hdc_exit_counter u_exit (
    .clk    (aclk),
    .rst_n  (aresetn),
    .ce     (ce),
    .clear  (state_q == hdc_pkg::HDC_TRACK),
    .tick   (pd_tick),
    .lock   (loop1_lock_indicator),
    .target (exit_cnt),
    .done_q (exit_done)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      hdc_pkg::HDC_TRACK: begin
        if (force_hold || rail_trip || lock_event) begin
          state_d = hdc_pkg::HDC_HOLD;
        end
      end
      hdc_pkg::HDC_HOLD: begin
        // done is a flop, so lock must still stand in this very cycle
        if (!force_hold && !rail_trip && exit_done && loop1_lock_indicator) begin
          state_d = hdc_pkg::HDC_TRACK;
        end
      end
      default: state_d = hdc_pkg::HDC_TRACK;
    endcase
  end

  wire hold_d = (state_d == hdc_pkg::HDC_HOLD);
  // in holdover the tracked register is frozen, so it holds the last value
  wire [9:0] dac_d = fixed_sel ? fixed_val :
                     (hold_d ? trk_q : dac_track_in);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q            <= hdc_pkg::HDC_TRACK;
      holdover_q         <= 1'b0;
      dac_code_q         <= 10'h000;
      trk_q              <= 10'h000;
      lock_prev_q        <= 1'b0;
      switch_event_q     <= 1'b0;
      dac_floor_flag_q   <= 1'b0;
      dac_ceiling_flag_q <= 1'b0;
    end else if (ce) begin
      state_q            <= state_d;
      holdover_q         <= hold_d;
      dac_code_q         <= dac_d;
      if (!hold_d) begin
        trk_q            <= dac_track_in;
      end
      lock_prev_q        <= loop1_lock_indicator;
      switch_event_q     <= switch_d;
      dac_floor_flag_q   <= floor_hit;
      dac_ceiling_flag_q <= ceil_hit;
    end
  end

  // register writes; the read-back address never takes a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_cfg_q <= hdc_pkg::RST_REG;
      trip_cfg_q   <= hdc_pkg::RST_REG;
      dac_ctrl_q   <= hdc_pkg::RST_REG;
      xtal_cfg_q   <= hdc_pkg::RST_REG;
      lf_dly_cfg_q <= hdc_pkg::RST_REG;
    end else if (ce) begin
      if (wr_switch) switch_cfg_q <= merge(switch_cfg_q, w_data_q, w_strb_q,
                                           hdc_pkg::MASK_SWITCH_CFG);
      if (wr_trip)   trip_cfg_q   <= merge(trip_cfg_q, w_data_q, w_strb_q,
                                           hdc_pkg::MASK_TRIP_CFG);
      if (wr_ctrl)   dac_ctrl_q   <= merge(dac_ctrl_q, w_data_q, w_strb_q,
                                           hdc_pkg::MASK_DAC_CTRL);
      if (wr_xtal)   xtal_cfg_q   <= merge(xtal_cfg_q, w_data_q, w_strb_q,
                                           hdc_pkg::MASK_XTAL_CFG);
      if (wr_lf)     lf_dly_cfg_q <= merge(lf_dly_cfg_q, w_data_q, w_strb_q,
                                           hdc_pkg::MASK_LF_DLY_CFG);
    end
  end

  // axi channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 12'h000;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hdc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= hdc_pkg::RESP_OKAY;
    end else if (ce) begin
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      if (aw_take) aw_addr_q <= s_axi_awaddr;
      if (w_take) begin
        w_data_q    <= s_axi_wdata;
        w_strb_q    <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_have_d & ~bvalid_d;
      s_axi_wready  <= ~w_have_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      if (do_write) s_axi_bresp <= wr_ok ? hdc_pkg::RESP_OKAY : hdc_pkg::RESP_SLVERR;
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? hdc_pkg::RESP_OKAY : hdc_pkg::RESP_SLVERR;
      end
    end
  end

  // checks
  sequence s_lock_drop;
    lock_prev_q && !loop1_lock_indicator;
  endsequence

  property p_force_holds;
    @(posedge aclk) disable iff (!aresetn)
      (ce && force_hold) |=> holdover_q;
  endproperty
  a_force_holds: assert property (p_force_holds) else $error("forced but not in holdover");

  property p_fixed_drive;
    @(posedge aclk) disable iff (!aresetn)
      (ce && fixed_sel) |=> (dac_code_q == $past(fixed_val));
  endproperty
  a_fixed_drive: assert property (p_fixed_drive) else $error("fixed value not driven");

  property p_track_hold;
    @(posedge aclk) disable iff (!aresetn)
      (ce && holdover_q && hold_d && !fixed_sel) |=> (dac_code_q == $past(trk_q)) && $stable(trk_q);
  endproperty
  a_track_hold: assert property (p_track_hold) else $error("dac moved in holdover");

  property p_lock_switch;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !lock_mask) ##0 s_lock_drop |=> switch_event_q;
  endproperty
  a_lock_switch: assert property (p_lock_switch) else $error("lock loss gave no switch");

  property p_mask_quiet;
    @(posedge aclk) disable iff (!aresetn)
      (ce && !rail_en) |=> !switch_event_q || $past(lock_event);
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("unexpected switch event");

  property p_rail_hold;
    @(posedge aclk) disable iff (!aresetn)
      (ce && rail_en && (floor_hit || ceil_hit)) |=> holdover_q;
  endproperty
  a_rail_hold: assert property (p_rail_hold) else $error("trip did not enter holdover");

  property p_flags;
    @(posedge aclk) disable iff (!aresetn)
      ce |=> (dac_floor_flag_q == $past(floor_hit)) && (dac_ceiling_flag_q == $past(ceil_hit));
  endproperty
  a_flags: assert property (p_flags) else $error("trip flags wrong");

  property p_exit_needs_lock;
    @(posedge aclk) disable iff (!aresetn)
      (ce && holdover_q && !hold_d) |-> exit_done && loop1_lock_indicator && !force_hold;
  endproperty
  a_exit_needs_lock: assert property (p_exit_needs_lock) else $error("left holdover early");

  property p_readback;
    @(posedge aclk) disable iff (!aresetn)
      (ce && ar_take && s_axi_araddr == hdc_pkg::ADDR_READBACK) |=>
        s_axi_rvalid && s_axi_rdata[23:14] == $past(trk_q);
  endproperty
  a_readback: assert property (p_readback) else $error("read-back mismatch");
endmodule // hdc_holdover_ctrl

// *** bench/hdc_vcxo_model.sv ***
/*
  hdc_vcxo_model: stand-in for the first loop's tuning path: tracked dac
  code, phase-detector tick and lock level. Assumes the bench sets code and
  lock just after a rising edge of aclk.
*/
`timescale 1ns/100ps
module hdc_vcxo_model #(
  parameter int PD_DIV = 4
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench controls
  input  wire logic [9:0] set_code,
  input  wire logic       set_lock,
  // toward the block
  output logic [9:0]      dac_track_in,
  output logic            pd_tick,
  output logic            loop1_lock_indicator
);
  logic [7:0] div_q;
  // the loop answers one edge late, as a real tracking loop would
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= (div_q == 8'(PD_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
    pd_tick <= aresetn && (div_q == 8'(PD_DIV - 1));
    dac_track_in <= set_code;
    loop1_lock_indicator <= set_lock;
  end
endmodule // hdc_vcxo_model

// *** bench/test_hdc_holdover_ctrl.sv ***
/*
  test_hdc_holdover_ctrl: self-checking bench for the holdover control block.
  Assumes the tuning-path model in hdc_vcxo_model and a 100 MHz aclk.
*/
`timescale 1ns/100ps
module test_hdc_holdover_ctrl;
  typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] rd; logic [1:0] rs;} hdc_row_t;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, lock;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic        awready, wready, bvalid, arready, rvalid, pd_tick, lock_ind;
  logic        hold, sw_ev, floor_f, ceil_f;
  logic [9:0]  dac_q, trk, code;
  logic [1:0]  xtal;
  logic [3:0]  c4, c3;
  logic [2:0]  r4, r3, fbd, refd;
  int          n_fail, checks, cyc, n_sw, sw0;
  hdc_row_t    rows [9];

  hdc_vcxo_model #(.PD_DIV(4)) hdc_vcxo_model_i (.aclk(aclk), .aresetn(aresetn),
    .set_code(code), .set_lock(lock), .dac_track_in(trk), .pd_tick(pd_tick),
    .loop1_lock_indicator(lock_ind));
  hdc_holdover_ctrl hdc_holdover_ctrl_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .dac_track_in(trk), .pd_tick(pd_tick), .loop1_lock_indicator(lock_ind),
    .dac_code_q(dac_q), .holdover_q(hold), .switch_event_q(sw_ev),
    .dac_floor_flag_q(floor_f), .dac_ceiling_flag_q(ceil_f),
    .crystal_drive_level(xtal), .loop2_cap_c4_select(c4), .loop2_cap_c3_select(c3),
    .loop2_res_r4_select(r4), .loop2_res_r3_select(r3),
    .loop1_feedback_delay(fbd), .loop1_reference_delay(refd));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // switch events are pulses, so they are counted rather than sampled
  always @(posedge aclk) begin
    cyc++;
    if (sw_ev === 1'b1) n_sw++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    chk_val(32'(got), 32'(exp));
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {n_fail, checks, cyc, n_sw} = '0;
    aresetn = 1'b0;
    lock = 1'b1;
    code = 10'h200;
    // mask rows write every bit and expect only the writable ones back
    rows = '{'{12'h034, 32'hFFFFFFFF, 32'h00008000, 2'h0}, '{12'h034, 0, 0, 2'h0},
             '{12'h038, 32'hFFF0301F, 0, 2'h0}, '{12'h03C, 32'hFFDFFFC0, 32'hFFDFFFC0, 2'h0},
             '{12'h03C, 0, 0, 2'h0}, '{12'h040, 32'hFFFFFFFF, 32'hC0000000, 2'h0},
             '{12'h060, 32'hFFFFFFFF, 32'hFF777700, 2'h0},
             '{12'h060, 32'hD5426500, 32'hD5426500, 2'h0},
             '{12'h100, 32'hFFFFFFFF, 0, hdc_pkg::RESP_SLVERR}};
    wait_cyc(12);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_rd(rows[i].a, rd, rs);
      chk_val(rd, 0);
    end
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].wd, rs);
      chk_val(32'(rs), 32'(rows[i].rs));
      axi_rd(rows[i].a, rd, rs);
      chk_val(rd, rows[i].rd);
      chk_val(32'(rs), 32'(rows[i].rs));
    end
    axi_wr(12'h040, 32'h80000000, rs);
    chk_val(32'({xtal, c4, c3, r4, r3, fbd, refd}), 32'h002D58B5);
    code <= 10'h155;
    wait_cyc(4);
    chk_val(32'(dac_q), 32'h155);
    // the read-back word is only ever read, never written
    axi_rd(12'h05C, rd, rs);
    chk_val(32'(rd[23:14]), 32'h155);
    sw0 = n_sw;
    axi_wr(12'h03C, 32'h000000E0, rs);
    wait_cyc(2);
    chk_val(32'(hold), 1);
    code <= 10'h0AA;
    wait_cyc(4);
    chk_val(32'(dac_q), 32'h155);
    chk_cnt(n_sw, sw0);
    axi_wr(12'h03C, 32'hAAD000E0, rs);
    wait_cyc(2);
    chk_val(32'(dac_q), 32'h2AB);
    axi_wr(12'h034, 32'h00008000, rs);
    // lock drops before the force is lifted, else the count made while forced lets it leave
    lock <= 1'b0;
    axi_wr(12'h03C, 32'h000000C0, rs);
    wait_cyc(20);
    chk_val(32'(hold), 1);
    chk_cnt(n_sw, sw0);
    lock <= 1'b1;
    wait_cyc(6);
    lock <= 1'b0;
    wait_cyc(1);
    lock <= 1'b1;
    wait_cyc(6);
    chk_val(32'(hold), 1);
    wait_cyc(14);
    chk_val(32'(hold), 0);
    axi_wr(12'h034, 0, rs);
    sw0 = n_sw;
    lock <= 1'b0;
    wait_cyc(4);
    chk_val(32'(hold), 1);
    chk_cnt(n_sw, sw0 + 1);
    lock <= 1'b1;
    wait_cyc(20);
    chk_val(32'(hold), 0);
    // thresholds at code 0: floor trips at 15 and below, ceiling at 1008 and up
    foreach (rows[i]) if (i < 4) begin
      code <= (i == 0) ? 10'd16 : (i == 1) ? 10'd15 : (i == 2) ? 10'd1007 : 10'd1008;
      wait_cyc(4);
      chk_val(32'({floor_f, ceil_f}), (i == 1) ? 2 : (i == 3) ? 1 : 0);
      chk_val(32'(hold), 0);
    end
    code <= 10'h200;
    axi_wr(12'h038, 32'h00000020, rs);
    sw0 = n_sw;
    code <= 10'd15;
    wait_cyc(5);
    chk_val(32'(hold), 1);
    chk_cnt(n_sw, sw0 + 1);
    // status: holdover, floor flag and lock set, switch pulse already gone
    axi_rd(12'h080, rd, rs);
    chk_val(rd, 32'h00000015);
    // a second reset mid-run clears the trip enable and leaves holdover
    aresetn <= 1'b0;
    wait_cyc(2);
    aresetn <= 1'b1;
    axi_rd(12'h038, rd, rs);
    chk_val(rd, 0);
    chk_val(32'(hold), 0);
    report_and_stop();
  end
endmodule // test_hdc_holdover_ctrl
